// [hdl/nand_host_params.svh]
// constants for the nand host controller: offsets, fields, opcodes, timing
`ifndef NAND_HOST_PARAMS_SVH
`define NAND_HOST_PARAMS_SVH
// clock and timing, times in ns
`define CLK_MHZ 250
`define T_WC_NS 25
`define T_REA_NS 20
`define T_WB_NS 100
`define T_WHR_NS 80
`define T_BUSY_MAX_NS 1000000
`define WC_CYC ((`T_WC_NS * `CLK_MHZ + 999) / 1000)
`define REA_CYC (((`T_REA_NS * `CLK_MHZ + 999) / 1000) + 3)
`define WB_CYC ((`T_WB_NS * `CLK_MHZ + 999) / 1000)
`define WHR_CYC ((`T_WHR_NS * `CLK_MHZ + 999) / 1000)
`define BUSY_MAX_CYC ((`T_BUSY_MAX_NS * `CLK_MHZ) / 1000)
`define SETUP_CYC 2
// register byte offsets
`define REG_CTRL 8'h00
`define REG_ADDR0 8'h04
`define REG_ADDR1 8'h08
`define REG_STATUS 8'h0C
`define REG_WPCTL 8'h10
`define REG_BUF 8'h20
// addr1 fields
`define AD1_A5_LSB 0
`define AD1_DATA_LSB 8
`define AD1_CNT_LSB 16
// status bits
`define ST_SEQ_BUSY 0
`define ST_REFUSED 1
`define ST_RST_DONE 2
`define ST_TIMEOUT 3
`define ST_OTP_EN 4
`define ST_ECC_EN 5
`define ST_RB 6
`define ST_ID_OK 7
`define ST_STAT_OK 8
`define ST_ID_MODE 9
`define ST_DATA_VALID 10
// reset values
`define WPCTL_RST 1'b1
// flash opcodes
`define OPC_RESET 8'hFF
`define OPC_READ 8'h00
`define OPC_PROG 8'h80
`define OPC_CONF_PROG 8'h10
`define OPC_CONF_READ 8'h30
`define OPC_CACHE_SEQ 8'h31
`define OPC_CACHE_LAST 8'h3F
`define OPC_CACHE_PROG 8'h15
`define OPC_MOVE_CONF 8'h35
`define OPC_MOVE_PROG 8'h85
`define OPC_ID 8'h90
`define OPC_STATUS 8'h70
`define OPC_SETFEAT 8'hEF
// identification, feature and status byte values
`define ID_ADDR_CODE 8'h00
`define ID_ADDR_SIG 8'h20
`define FEAT_OTP_ADDR 8'h90
`define FEAT_OTP_BIT 0
`define FEAT_ECC_BIT 3
`define ID_B2 8'h80
`define ID_B3 8'hA6
`define ID_B4_LOW 7'h62
`define SIG_B0 8'h4F
`define SIG_B1 8'h4E
`define SIG_B2 8'h46
`define SIG_B3 8'h49
`define STAT_WP_OFF 8'hE0
`define STAT_WP_ON 8'h60
`endif

// [hdl/nand_host_pkg.sv]
// types shared by the nand host controller
package nand_host_pkg;
  typedef enum logic [3:0] {
    OP_RESET, OP_ID_CODE, OP_ID_SIG, OP_SET_FEAT, OP_OTP_LOCK, OP_OTP_PROG,
    OP_OTP_READ, OP_PAGE_READ, OP_CACHE_SEQ, OP_CACHE_RND, OP_CACHE_LAST,
    OP_CACHE_PROG, OP_MOVE_READ, OP_MOVE_PROG, OP_NONE
  } op_t;
  typedef enum logic [3:0] {
    S_IDLE, S_CMD1, S_ADDR, S_DIN, S_CMD2, S_WB, S_BUSY, S_STAT, S_WHR, S_DOUT
  } state_t;
  typedef struct packed {
    logic [7:0] c1;
    logic [2:0] na;
    logic din;
    logic hc2;
    logic [7:0] c2;
    logic wt;
    logic dout;
  } seq_t;
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic wp_n;
    logic io_oe;
    logic [7:0] io_out;
  } nand_pins_t;
endpackage : nand_host_pkg

// [hdl/byte_buf.sv]
// small byte memory with registered read data
`timescale 1ns/1ps
module byte_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock
  input wire logic aclk,
  // write port
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read port
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : byte_buf

// [hdl/nand_host_ctrl.sv]
// nand flash host controller: axi4-lite command registers, pin sequencer
`timescale 1ns/1ps
`include "nand_host_params.svh"

// Overview of operation
// - otp lock 80h, five addresses, 10h
// - otp program 80h, addresses, data, 10h
// - otp read 00h, five addresses, 30h
// - otp commands only after feature enable
// - cache read only after read commands; the code refuses it only right after a cache program
// - cache program only after cache program; the code refuses it only right after a cache read
// - internal move stays inside one plane
// - reset is first command after power-on
// - identification only while all dies idle
module nand_host_ctrl
  import nand_host_pkg::*;
#(
  parameter int BUF_DEPTH = 8,
  parameter int BUSY_MAX_CYC = `BUSY_MAX_CYC,
  parameter int PLANE_BIT = 22
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // flash pins
  output nand_pins_t nand_o,
  input wire logic [7:0] nand_io_i,
  input wire logic nand_rb_n_i
);
  localparam int BAW = $clog2(BUF_DEPTH);
  localparam int TMO_W = $clog2(BUSY_MAX_CYC + 1);
  localparam logic [7:0] WC = 8'(`WC_CYC);
  localparam logic [7:0] REA = 8'(`REA_CYC);
  localparam logic [7:0] WB = 8'(`WB_CYC);
  localparam logic [7:0] WHR = 8'(`WHR_CYC);
  localparam logic [7:0] SETUP = 8'(`SETUP_CYC);

  logic [7:0] io_m_r, io_s_r;
  logic rb_m_r, rb_s_r;
  logic aw_hold_r, w_hold_r, ar_pend_r;
  logic [7:0] aw_addr_r, raddr_r;
  logic [31:0] w_data_r, addr0_r, addr1_r;
  logic [3:0] w_strb_r;
  logic wp_r, start_r, refuse, accept, wr_en, in_buf;
  op_t start_op_r, op_r, prev_op_r;
  state_t state_r, nxt, tail_a, tail_d, tail_c;
  seq_t seq_r;
  logic lo_r, refused_r, tmo_flag_r, reset_done_r, otp_en_r, ecc_r;
  logic id_mode_r, id_ok_r, stat_ok_r, data_valid_r, array_busy_r, src_plane_r;
  logic [7:0] cnt_r, idx_r, nbytes_r, cnt_load, out_byte;
  logic [39:0] abuf_r;
  logic [TMO_W-1:0] tmo_r;
  logic sample, buf_we, strobe, wr_state;
  logic [7:0] buf_rd;
  logic [31:0] status_w;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
    end
    return r;
  endfunction : merge

  function automatic seq_t desc(input op_t op);
    seq_t s;
    s = '0;
    case (op)
      OP_RESET: begin s.c1 = `OPC_RESET; s.wt = 1'b1; end
      OP_ID_CODE, OP_ID_SIG: begin s.c1 = `OPC_ID; s.na = 3'd1; s.dout = 1'b1; end
      OP_SET_FEAT: begin s.c1 = `OPC_SETFEAT; s.na = 3'd1; s.din = 1'b1; s.wt = 1'b1; end
      OP_OTP_LOCK: begin s.c1 = `OPC_PROG; s.na = 3'd5; s.hc2 = 1'b1;
        s.c2 = `OPC_CONF_PROG; s.wt = 1'b1; end
      OP_OTP_PROG: begin s.c1 = `OPC_PROG; s.na = 3'd5; s.din = 1'b1; s.hc2 = 1'b1;
        s.c2 = `OPC_CONF_PROG; s.wt = 1'b1; end
      OP_OTP_READ, OP_PAGE_READ: begin s.c1 = `OPC_READ; s.na = 3'd5; s.hc2 = 1'b1;
        s.c2 = `OPC_CONF_READ; s.wt = 1'b1; s.dout = 1'b1; end
      OP_CACHE_SEQ: begin s.c1 = `OPC_CACHE_SEQ; s.wt = 1'b1; s.dout = 1'b1; end
      OP_CACHE_RND: begin s.c1 = `OPC_READ; s.na = 3'd5; s.hc2 = 1'b1;
        s.c2 = `OPC_CACHE_SEQ; s.wt = 1'b1; s.dout = 1'b1; end
      OP_CACHE_LAST: begin s.c1 = `OPC_CACHE_LAST; s.wt = 1'b1; s.dout = 1'b1; end
      OP_CACHE_PROG: begin s.c1 = `OPC_PROG; s.na = 3'd5; s.din = 1'b1; s.hc2 = 1'b1;
        s.c2 = `OPC_CACHE_PROG; s.wt = 1'b1; end
      OP_MOVE_READ: begin s.c1 = `OPC_READ; s.na = 3'd5; s.hc2 = 1'b1;
        s.c2 = `OPC_MOVE_CONF; s.wt = 1'b1; end
      OP_MOVE_PROG: begin s.c1 = `OPC_MOVE_PROG; s.na = 3'd5; s.din = 1'b1;
        s.hc2 = 1'b1; s.c2 = `OPC_CONF_PROG; s.wt = 1'b1; end
      default: s = '0;
    endcase
    return s;
  endfunction : desc

  ////////////////////////////////////////////////////////////////////////////////
  // pin input synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_m_r <= 8'h00;
      io_s_r <= 8'h00;
      rb_m_r <= 1'b0;
      rb_s_r <= 1'b0;
    end else begin
      io_m_r <= nand_io_i;
      io_s_r <= io_m_r;
      rb_m_r <= nand_rb_n_i;
      rb_s_r <= rb_m_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi write channel and registers
  assign wr_en = aw_hold_r && w_hold_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      addr0_r <= 32'h0;
      addr1_r <= 32'h0;
      wp_r <= `WPCTL_RST;
      start_r <= 1'b0;
      start_op_r <= OP_NONE;
    end else begin
      start_r <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_en) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case (aw_addr_r)
          `REG_CTRL: begin
            start_r <= w_strb_r[0];
            start_op_r <= op_t'(w_data_r[3:0]);
          end
          `REG_ADDR0: addr0_r <= merge(addr0_r, w_data_r, w_strb_r);
          `REG_ADDR1: addr1_r <= merge(addr1_r, w_data_r, w_strb_r);
          `REG_WPCTL: if (w_strb_r[0]) wp_r <= w_data_r[0];
          default: s_axi_bresp <= 2'h2;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi read channel
  assign in_buf = (int'(raddr_r) >= int'(`REG_BUF)) &&
                  (int'(raddr_r) < int'(`REG_BUF) + 4 * BUF_DEPTH);
  always_comb begin
    status_w = 32'h0;
    status_w[`ST_SEQ_BUSY] = (state_r != S_IDLE);
    status_w[`ST_REFUSED] = refused_r;
    status_w[`ST_RST_DONE] = reset_done_r;
    status_w[`ST_TIMEOUT] = tmo_flag_r;
    status_w[`ST_OTP_EN] = otp_en_r;
    status_w[`ST_ECC_EN] = ecc_r;
    status_w[`ST_RB] = rb_s_r;
    status_w[`ST_ID_OK] = id_ok_r;
    status_w[`ST_STAT_OK] = stat_ok_r;
    status_w[`ST_ID_MODE] = id_mode_r;
    status_w[`ST_DATA_VALID] = data_valid_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
      ar_pend_r <= 1'b0;
      raddr_r <= 8'h00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        ar_pend_r <= 1'b1;
        raddr_r <= s_axi_araddr;
      end
      if (ar_pend_r) begin
        ar_pend_r <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (raddr_r)
          `REG_CTRL: s_axi_rdata <= {28'h0, prev_op_r};
          `REG_ADDR0: s_axi_rdata <= addr0_r;
          `REG_ADDR1: s_axi_rdata <= addr1_r;
          `REG_STATUS: s_axi_rdata <= status_w;
          `REG_WPCTL: s_axi_rdata <= {31'h0, wp_r};
          default: begin
            s_axi_rdata <= in_buf ? {24'h0, buf_rd} : 32'h0;
            s_axi_rresp <= in_buf ? 2'h0 : 2'h2;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // command acceptance
  always_comb begin
    refuse = 1'b0;
    if (start_op_r != OP_RESET) begin
      if (!reset_done_r || state_r != S_IDLE || start_op_r == OP_NONE) refuse = 1'b1;
      if (start_op_r == op_t'(4'hF)) refuse = 1'b1;
      if (!rb_s_r) refuse = 1'b1;
      if ((start_op_r == OP_OTP_LOCK || start_op_r == OP_OTP_PROG ||
           start_op_r == OP_OTP_READ) && !otp_en_r) refuse = 1'b1;
      if (array_busy_r && (start_op_r == OP_CACHE_SEQ || start_op_r == OP_CACHE_RND ||
          start_op_r == OP_CACHE_LAST) && !(prev_op_r == OP_PAGE_READ ||
          prev_op_r == OP_CACHE_SEQ || prev_op_r == OP_CACHE_RND)) refuse = 1'b1;
      if (array_busy_r && start_op_r == OP_CACHE_PROG && prev_op_r != OP_CACHE_PROG)
        refuse = 1'b1;
      if (start_op_r == OP_MOVE_PROG && (prev_op_r != OP_MOVE_READ ||
          1'({addr1_r[7:0], addr0_r} >> PLANE_BIT) != src_plane_r)) refuse = 1'b1;
    end
  end
  assign accept = start_r && !refuse;

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer next-step decode
  assign strobe = state_r inside {S_CMD1, S_ADDR, S_DIN, S_CMD2, S_STAT, S_DOUT};
  assign wr_state = strobe && state_r != S_DOUT;
  // sample at end of read low phase
  assign sample = state_r == S_DOUT && lo_r && cnt_r == 8'h00;
  assign buf_we = sample && op_r != OP_RESET && int'(idx_r) < BUF_DEPTH;

  always_comb begin
    tail_c = seq_r.wt ? S_WB : (seq_r.dout ? S_WHR : S_IDLE);
    tail_d = seq_r.hc2 ? S_CMD2 : tail_c;
    tail_a = seq_r.din ? S_DIN : tail_d;
    case (state_r)
      S_CMD1: nxt = (seq_r.na != 3'd0) ? S_ADDR : tail_a;
      S_ADDR: nxt = (idx_r == 8'({5'h0, seq_r.na} - 8'd1)) ? tail_a : S_ADDR;
      S_DIN: nxt = (idx_r == nbytes_r - 8'd1) ? tail_d : S_DIN;
      S_CMD2: nxt = tail_c;
      S_STAT: nxt = S_WHR;
      S_DOUT: nxt = (idx_r == nbytes_r - 8'd1) ? S_IDLE : S_DOUT;
      default: nxt = S_IDLE;
    endcase
    cnt_load = (nxt == S_WB) ? WB - 8'd1 : (nxt == S_WHR) ? WHR - 8'd1 :
               (nxt == S_DOUT) ? REA - 8'd1 : WC - 8'd1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer and host-side flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= S_IDLE;
      seq_r <= '0;
      op_r <= OP_NONE;
      prev_op_r <= OP_NONE;
      lo_r <= 1'b0;
      cnt_r <= 8'h00;
      idx_r <= 8'h00;
      nbytes_r <= 8'h01;
      abuf_r <= 40'h0;
      tmo_r <= '0;
      {refused_r, tmo_flag_r, reset_done_r, otp_en_r, ecc_r} <= 5'h0;
      {id_mode_r, id_ok_r, stat_ok_r, data_valid_r, array_busy_r, src_plane_r} <= 6'h0;
    end else begin
      if (start_r && refuse) refused_r <= 1'b1;
      if (accept) begin
        {refused_r, tmo_flag_r} <= 2'b00;
        op_r <= start_op_r;
        seq_r <= desc(start_op_r);
        prev_op_r <= start_op_r;
        state_r <= S_CMD1;
        lo_r <= 1'b1;
        cnt_r <= WC - 8'd1;
        idx_r <= 8'h00;
        abuf_r <= {addr1_r[7:0], addr0_r};
        nbytes_r <= (addr1_r[`AD1_CNT_LSB +: 8] == 8'h00) ? 8'h01 : addr1_r[`AD1_CNT_LSB +: 8];
        array_busy_r <= start_op_r inside {OP_CACHE_SEQ, OP_CACHE_RND, OP_CACHE_PROG};
        // id mode held until next command
        id_mode_r <= start_op_r inside {OP_ID_CODE, OP_ID_SIG};
        if (start_op_r == OP_ID_CODE) begin
          abuf_r <= {32'h0, `ID_ADDR_CODE};
          nbytes_r <= 8'd5;
          id_ok_r <= 1'b1;
        end
        if (start_op_r == OP_ID_SIG) begin
          abuf_r <= {32'h0, `ID_ADDR_SIG};
          nbytes_r <= 8'd4;
          id_ok_r <= 1'b1;
        end
        if (start_op_r == OP_SET_FEAT) nbytes_r <= 8'd4;
        if (start_op_r == OP_MOVE_READ) src_plane_r <= 1'({addr1_r[7:0], addr0_r} >> PLANE_BIT);
        if (start_op_r == OP_SET_FEAT && addr0_r[7:0] == `FEAT_OTP_ADDR) begin
          otp_en_r <= addr1_r[`AD1_DATA_LSB + `FEAT_OTP_BIT];
          ecc_r <= addr1_r[`AD1_DATA_LSB + `FEAT_ECC_BIT];
        end
        if (start_op_r == OP_RESET) begin
          prev_op_r <= OP_NONE;
          array_busy_r <= 1'b0;
          {data_valid_r, reset_done_r, stat_ok_r} <= 3'b000;
          nbytes_r <= 8'h01;
        end
      end else if (strobe) begin
        if (cnt_r != 8'h00) begin
          cnt_r <= cnt_r - 8'd1;
        end else if (lo_r) begin
          lo_r <= 1'b0;
          cnt_r <= WC - 8'd1;
        end else begin
          state_r <= nxt;
          lo_r <= 1'b1;
          cnt_r <= cnt_load;
          idx_r <= (nxt == state_r) ? idx_r + 8'd1 : 8'h00;
          if (state_r == S_ADDR) abuf_r <= {8'h00, abuf_r[39:8]};
          if (state_r == S_DOUT && nxt == S_IDLE) begin
            data_valid_r <= op_r != OP_RESET;
            if (op_r == OP_RESET) reset_done_r <= 1'b1;
          end
        end
        if (sample) begin
          if (op_r == OP_RESET)
            stat_ok_r <= io_s_r == (wp_r ? `STAT_WP_OFF : `STAT_WP_ON);
          if (op_r == OP_ID_CODE) begin
            case (idx_r)
              8'd2: if (io_s_r != `ID_B2) id_ok_r <= 1'b0;
              8'd3: if (io_s_r != `ID_B3) id_ok_r <= 1'b0;
              8'd4: if (io_s_r != {ecc_r, `ID_B4_LOW}) id_ok_r <= 1'b0;
              default: ;
            endcase
          end
          if (op_r == OP_ID_SIG && io_s_r != (idx_r == 8'd0 ? `SIG_B0 : idx_r == 8'd1 ?
              `SIG_B1 : idx_r == 8'd2 ? `SIG_B2 : `SIG_B3)) id_ok_r <= 1'b0;
        end
      end else begin
        case (state_r)
          S_WB, S_WHR: begin
            if (cnt_r != 8'h00) begin
              cnt_r <= cnt_r - 8'd1;
            end else begin
              state_r <= (state_r == S_WB) ? S_BUSY : S_DOUT;
              lo_r <= 1'b1;
              cnt_r <= REA - 8'd1;
              idx_r <= 8'h00;
              tmo_r <= '0;
            end
          end
          S_BUSY: begin
            if (rb_s_r) begin
              state_r <= (op_r == OP_RESET) ? S_STAT : (seq_r.dout ? S_WHR : S_IDLE);
              lo_r <= 1'b1;
              cnt_r <= (op_r == OP_RESET) ? WC - 8'd1 : WHR - 8'd1;
            end else if (int'(tmo_r) == BUSY_MAX_CYC - 1) begin
              tmo_flag_r <= 1'b1;
              state_r <= S_IDLE;
            end else begin
              tmo_r <= tmo_r + 1'b1;
            end
          end
          default: state_r <= S_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin drivers
  always_comb begin
    case (state_r)
      S_CMD1: out_byte = seq_r.c1;
      S_CMD2: out_byte = seq_r.c2;
      S_STAT: out_byte = `OPC_STATUS;
      S_ADDR: out_byte = abuf_r[7:0];
      // only the first feature parameter carries data
      S_DIN: out_byte = (op_r == OP_SET_FEAT && idx_r != 8'h00) ? 8'h00 :
                        addr1_r[`AD1_DATA_LSB +: 8];
      default: out_byte = 8'h00;
    endcase
  end

  // we_n trails the latches by SETUP cycles so cle, ale and data settle first; re_n does not trail
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nand_o <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
                  wp_n: `WPCTL_RST, io_oe: 1'b0, io_out: 8'h00};
    end else begin
      nand_o.ce_n <= state_r == S_IDLE;
      nand_o.cle <= state_r inside {S_CMD1, S_CMD2, S_STAT};
      nand_o.ale <= state_r == S_ADDR;
      nand_o.we_n <= !(wr_state && lo_r && cnt_r < WC - SETUP);
      nand_o.re_n <= !(state_r == S_DOUT && lo_r);
      nand_o.wp_n <= wp_r;
      nand_o.io_oe <= wr_state;
      nand_o.io_out <= out_byte;
    end
  end

  byte_buf #(.WIDTH(8), .DEPTH(BUF_DEPTH)) u_buf (
    .aclk(aclk),
    .wr_en(buf_we),
    .wr_addr(idx_r[BAW-1:0]),
    .wr_data(io_s_r),
    .rd_addr(s_axi_araddr[BAW+1:2]),
    .rd_data(buf_rd)
  );
endmodule : nand_host_ctrl

// [testbench/nand_host_monitor.sv]
// port checks for the nand host controller
`timescale 1ns/1ps
module nand_host_monitor
  import nand_host_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // flash pins
  input wire nand_pins_t nand_o
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // byte strobes have fixed widths so slow parts still latch
  sequence we_pulse;
    !nand_o.we_n [*5] ##1 nand_o.we_n;
  endsequence
  sequence re_pulse;
    !nand_o.re_n [*8] ##1 nand_o.re_n;
  endsequence
  AST_WR_ANSWER: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read answer late");
  AST_RD_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  AST_WE_WIDTH: assert property ($fell(nand_o.we_n) |-> we_pulse)
    else $error("write strobe width");
  AST_RE_WIDTH: assert property ($fell(nand_o.re_n) |-> re_pulse)
    else $error("read strobe width");
  AST_STROBES: assert property (!(!nand_o.we_n && !nand_o.re_n))
    else $error("both strobes low");
  AST_CE_FRAME: assert property (!nand_o.we_n || !nand_o.re_n |-> !nand_o.ce_n)
    else $error("strobe without chip enable");
  AST_NO_DRIVE: assert property (!nand_o.re_n |-> !nand_o.io_oe && !nand_o.cle)
    else $error("host drives during read");
endmodule : nand_host_monitor

// [testbench/nand_target_model.sv]
// behavioural flash target for the host bench
`timescale 1ns/1ps
module nand_target_model
  import nand_host_pkg::*;
#(
  parameter logic [39:0] ID_CODE = 40'h62A680A55A, // bytes 0 and 1 arbitrary
  parameter int BUSY_NS = 400
) (
  // host pins
  input wire nand_pins_t pins,
  // answers
  output logic [7:0] io,
  output logic rb_n
);
  logic [7:0] cmd = 8'h00;
  logic [7:0] feat = 8'h00;
  logic [7:0] stat = 8'hE0;
  logic [1:0] mode = 2'd0;
  logic ecc = 1'b0;
  logic bad = 1'b0;
  int na = 0;
  int idx = 0;
  event busy_ev;
  initial begin
    io = 8'h00;
    rb_n = 1'b1;
  end
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && pins.cle) begin
      if (pins.io_out inside {8'h10, 8'h30} && na != 5) bad = 1'b1;
      if (rb_n || pins.io_out != 8'h90) cmd = pins.io_out;
      na = 0;
      idx = 0;
      mode = (cmd == 8'h70) ? 2'd3 : 2'd0;
      if (cmd == 8'hFF) stat = pins.wp_n ? 8'hE0 : 8'h60;
      if (cmd inside {8'hFF, 8'h10, 8'h15, 8'h30, 8'h31, 8'h35, 8'h3F}) -> busy_ev;
    end else if (!pins.ce_n && pins.ale) begin
      na++;
      if (cmd == 8'h90) mode = (pins.io_out == 8'h00) ? 2'd1 : 2'd2;
      if (cmd == 8'hEF) feat = pins.io_out;
    end else if (!pins.ce_n) begin
      if (cmd == 8'hEF && idx == 0 && feat == 8'h90) ecc = pins.io_out[3];
      idx++;
    end
  end
  // a retrigger while busy is lost; fine for this bench
  always @(busy_ev) begin
    rb_n = 1'b0;
    #(BUSY_NS) rb_n = 1'b1;
  end
  always @(negedge pins.re_n) begin
    case (mode)
      2'd1: io = 8'({ecc, ID_CODE[38:0]} >> (8 * (idx % 5)));
      2'd2: io = 8'(32'h49464E4F >> (8 * (idx % 4)));
      2'd3: io = stat;
      default: io = 8'(idx);
    endcase
    idx++;
  end
  // released bus shows a new pattern, not the last byte
  always @(posedge pins.re_n) io = ~io;
endmodule : nand_target_model

// [testbench/testbench.sv]
// self-checking bench for the nand host controller
`timescale 1ns/1ps
`include "nand_host_params.svh"
module testbench;
  import nand_host_pkg::*;
  localparam logic [39:0] ID_CODE = 40'h62A680A55A; // bytes 0 and 1 arbitrary
  localparam logic [51:0] OPS = 52'hDDC9BBAB87654;
  localparam logic [12:0] REFS = 13'h0A20;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rb_n;
  logic [1:0] s_axi_bresp, s_axi_rresp, br, rr;
  logic [31:0] s_axi_rdata, st;
  logic [7:0] io;
  nand_pins_t pins;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  nand_host_ctrl #(.BUSY_MAX_CYC(200)) i_nand_host_ctrl (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .nand_o(pins), .nand_io_i(io), .nand_rb_n_i(rb_n));
  nand_target_model #(.ID_CODE(ID_CODE)) i_nand_target_model (.pins, .io, .rb_n);
  always #2 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  // the only end to a hang: a wait never times out on its own
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      summarize();
    end
  end
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) br = s_axi_bresp;
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
    end while (s_axi_bready);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) d = s_axi_rdata;
      if (s_axi_rvalid) rr = s_axi_rresp;
      if (s_axi_rvalid) s_axi_rready <= 1'b0;
    end while (s_axi_rready);
  endtask : rd
  task automatic run(input logic [3:0] op);
    wr(`REG_CTRL, {28'h0, op});
    do rd(`REG_STATUS, st); while (st[0] !== 1'b0);
  endtask : run
  task automatic step(input logic [3:0] op, input logic [31:0] a0, a1, input logic rf);
    wr(`REG_ADDR0, a0);
    wr(`REG_ADDR1, a1);
    run(op);
    check("refused", st[1], rf);
  endtask : step
  task automatic bytes(input logic [39:0] exp, input int n);
    for (int i = 0; i < n; i++) begin
      rd(8'(`REG_BUF + 4 * i), st);
      check("buffer byte", st, {24'h0, exp[8*i +: 8]});
    end
  endtask : bytes
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    step(4'h1, 32'h0, 32'h0, 1'b1);
    wr(`REG_WPCTL, 32'h0);
    step(4'h0, 32'h0, 32'h0, 1'b0);
    check("status wp low", st[8], 1'b1);
    wr(`REG_WPCTL, 32'h1);
    step(4'h0, 32'h0, 32'h0, 1'b0);
    check("status wp high", st[8], 1'b1);
    step(4'h6, 32'h0, 32'h0, 1'b1);
    step(4'h1, 32'h0, 32'h0, 1'b0);
    check("id mode", {st[9], st[7]}, 2'b11);
    bytes(ID_CODE, 5);
    step(4'h2, 32'h20, 32'h0, 1'b0);
    bytes(40'h49464E4F, 4);
    step(4'h3, 32'h90, 32'h0900, 1'b0);
    step(4'h1, 32'h0, 32'h0, 1'b0);
    bytes(ID_CODE | 40'h8000000000, 5);
    for (int i = 0; i < 13; i++) begin
      step(OPS[4*i +: 4], 32'(REFS[i]) << 22, 32'h30000, REFS[i]);
    end
    check("address cycles", i_nand_target_model.bad, 1'b0);
    wr(`REG_CTRL, 32'h6);
    // land the reset while the flash is busy, never inside a strobe
    repeat (130) @(posedge aclk);
    run(4'h0);
    check("abort reset", {st[10], st[8], st[2]}, 3'b011);
    rd(`REG_CTRL, st);
    check("last op", st, 32'hE);
    wr(8'h40, 32'h0);
    check("bresp", br, 2'h2);
    rd(8'h44, st);
    check("rresp", rr, 2'h2);
    summarize();
  end
endmodule : testbench
bind nand_host_ctrl nand_host_monitor i_nand_host_monitor (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .nand_o);
